/* File: shared/dfcc_pkg.sv */
package dfcc_pkg;
	// apb register byte offsets
	localparam logic [7:0] DFCC_OFS_CMD      = 8'h00; // function word, write launches
	localparam logic [7:0] DFCC_OFS_FEAT     = 8'h04; // feature code
	localparam logic [7:0] DFCC_OFS_STATE    = 8'h08; // state value
	localparam logic [7:0] DFCC_OFS_OPT      = 8'h0C; // option flags
	localparam logic [7:0] DFCC_OFS_RESULT   = 8'h10; // status, error, number, count
	localparam logic [7:0] DFCC_OFS_SETCACHE = 8'h14; // set-features cache request
	localparam logic [7:0] DFCC_OFS_INFO     = 8'h18; // live feature states
	localparam logic [7:0] DFCC_OFS_TEMP     = 8'h1C; // current temperature
	localparam logic [7:0] DFCC_OFS_QIDX     = 8'h20; // queue index
	localparam logic [7:0] DFCC_OFS_QRD      = 8'h24; // queue read addr / data
	localparam logic [7:0] DFCC_OFS_PERIOD   = 8'h28; // sample period
	localparam logic [7:0] DFCC_OFS_LIMITS   = 8'h2C; // four limits
	// function words
	localparam logic [15:0] DFCC_FN_SET   = 16'h0001;
	localparam logic [15:0] DFCC_FN_STATE = 16'h0002;
	localparam logic [15:0] DFCC_FN_OPT   = 16'h0003;
	// feature codes
	localparam logic [15:0] DFCC_FC_WCACHE  = 16'h0001;
	localparam logic [15:0] DFCC_FC_REORDER = 16'h0002;
	localparam logic [15:0] DFCC_FC_LOGINT  = 16'h0003;
	// states
	localparam logic [15:0] DFCC_WC_FOLLOW  = 16'h0001;
	localparam logic [15:0] DFCC_WC_FORCEON = 16'h0002;
	localparam logic [15:0] DFCC_WC_FORCEOF = 16'h0003;
	localparam logic [15:0] DFCC_RO_ENABLE  = 16'h0001;
	localparam logic [15:0] DFCC_RO_DISABLE = 16'h0002;
	localparam logic [15:0] DFCC_INT_DEF    = 16'h0001;
	localparam logic [15:0] DFCC_INT_BAD    = 16'h0000;
	localparam logic [15:0] DFCC_ZERO16     = 16'h0000;
	// taskfile answers
	localparam logic [7:0]  DFCC_ST_OK      = 8'h50;
	localparam logic [7:0]  DFCC_ST_ERR     = 8'h51;
	localparam logic [7:0]  DFCC_ER_NONE    = 8'h00;
	localparam logic [7:0]  DFCC_ER_ABORT   = 8'h04;
	localparam logic [7:0]  DFCC_Q_EMPTY    = 8'h80;
	localparam int          DFCC_OPT_NV_BIT = 0;
	localparam int          DFCC_ID85_BIT   = 5;
	localparam int          DFCC_QSIZE      = 128;
	typedef enum logic [3:0] {
		DFCC_IDLE  = 4'b0001,
		DFCC_EXEC  = 4'b0010,
		DFCC_CLEAR = 4'b0100,
		DFCC_DONE  = 4'b1000
	} dfcc_state_t;
endpackage : dfcc_pkg

/* File: rtl/dfcc_queue_mem.sv */
`timescale 1ns/1ps
// byte memory for the temperature history, registered read
module dfcc_queue_mem #(
	parameter int DEPTH = 128,
	parameter int AW    = 7
) (
	input  wire logic          clk_in,   // clock
	input  wire logic          ce_in,    // clock enable
	input  wire logic          we_in,    // write strobe
	input  wire logic [AW-1:0] waddr_in, // write address
	input  wire logic [7:0]    wdata_in, // write byte
	input  wire logic [AW-1:0] raddr_in, // read address
	output logic      [7:0]    rdata_out // registered read byte
);
	// elaboration check: every entry needs an address
	if (DEPTH > (1 << AW)) begin : g_bad_depth
		$error("dfcc_queue_mem: depth exceeds address width");
	end
	logic [7:0] mem [DEPTH]; // storage, no reset so it maps to ram
	always_ff @(posedge clk_in) begin
		if (ce_in) begin
			if (we_in) mem[waddr_in] <= wdata_in;
			rdata_out <= mem[raddr_in];
		end
	end
endmodule : dfcc_queue_mem

/* File: rtl/dfcc_nv_store.sv */
`timescale 1ns/1ps
// non-volatile copy of feature states; survives hard reset
// only a power-on (nv reset) reloads defaults, a hard reset does not touch it
module dfcc_nv_store
	import dfcc_pkg::*;
(
	input  wire logic        clk_in,      // clock
	input  wire logic        ce_in,       // clock enable
	input  wire logic        por_n_in,    // power-on reset, active low
	input  wire logic        we_in,       // persist strobe
	input  wire logic [15:0] feat_in,     // feature being persisted
	input  wire logic [15:0] val_in,      // value being persisted
	output logic      [15:0] wc_out,      // stored cache policy
	output logic      [15:0] ro_out,      // stored reorder state
	output logic      [15:0] int_out      // stored logging interval
);
	logic [15:0] wc_nxt, ro_nxt, int_nxt; // next values
	always_comb begin
		wc_nxt  = wc_out;
		ro_nxt  = ro_out;
		int_nxt = int_out;
		if (we_in) begin
			case (feat_in)
				DFCC_FC_WCACHE:  wc_nxt  = val_in;
				DFCC_FC_REORDER: ro_nxt  = val_in;
				DFCC_FC_LOGINT:  int_nxt = val_in;
				default: ; // nothing else persists
			endcase
		end
	end
	always_ff @(posedge clk_in or negedge por_n_in) begin
		if (!por_n_in) begin
			wc_out  <= DFCC_WC_FOLLOW;
			ro_out  <= DFCC_RO_ENABLE;
			int_out <= DFCC_INT_DEF;
		end else if (ce_in) begin
			wc_out  <= wc_nxt;
			ro_out  <= ro_nxt;
			int_out <= int_nxt;
		end
	end
endmodule : dfcc_nv_store

/* File: rtl/dfcc_top.sv */
`timescale 1ns/1ps
// Function
// - state 0001h: set-features decides caching
// - 0002h forces cache on, 0003h off
// - forced: set-features accepted, ignored, no error
// - word 85 bit 5 shows true cache
// - reset: cache and reorder states 0001h; a hard reset reloads the persisted states instead, only power-on gives 0001h
// - reorder: 0001h enables, 0002h disables
// - reorder 0002h completes ok but ignored
// - interval 0001h..FFFFh minutes, 0000h invalid
// - interval set clears queue, temp, 80h
// - queue clear keeps period and limits
// - logging interval defaults to 0001h
// - function 1 set, 2 state, 3 options
// - option bit 0 persists across hard reset
// - return state: LSB count, MSB number
module dfcc_top
	import dfcc_pkg::*;
#(
	parameter int QSIZE = DFCC_QSIZE, // history queue entries
	parameter int QAW   = 7           // queue address width
) (
	input  wire logic        CLK_SYS_IN,    // 100 MHz clock
	input  wire logic        RSTN_IN,       // hard reset, async, active low
	input  wire logic        POR_N_IN,      // power-on reset of nv store
	input  wire logic        CE_IN,         // clock enable
	input  wire logic        PSEL_IN,       // apb select
	input  wire logic        PENABLE_IN,    // apb enable
	input  wire logic        PWRITE_IN,     // apb direction
	input  wire logic [7:0]  PADDR_IN,      // apb byte address
	input  wire logic [31:0] PWDATA_IN,     // apb write data
	output logic      [31:0] PRDATA_OUT,    // apb read data
	output logic             PREADY_OUT,    // apb ready
	output logic             PSLVERR_OUT,   // apb error
	output logic             WCACHE_ON_OUT, // true cache state
	output logic             REORDER_OUT,   // reordering active
	output logic      [15:0] ID_WORD85_OUT  // identify word 85
);
	if (QSIZE < 2 || QSIZE > (1 << QAW) || QAW > 8) begin : g_bad_qsize
		$error("dfcc_top: bad queue size"); // pointers and 8-bit readout must hold it
	end
	// command registers written by software
	logic [15:0] fn_r, fn_nxt;       // function word
	logic [15:0] fc_r, fc_nxt;       // feature code
	logic [15:0] sv_r, sv_nxt;       // state value
	logic [15:0] opt_r, opt_nxt;     // option flags
	logic        sfc_r, sfc_nxt;     // set-features cache setting
	logic [7:0]  temp_r, temp_nxt;   // current temperature
	logic [15:0] period_r, period_nxt; // sample period
	logic [31:0] limits_r, limits_nxt; // four limit bytes
	logic [QAW-1:0] qra_r, qra_nxt;  // queue read address
	// live feature state
	logic [15:0] wc_r, wc_nxt;       // cache policy
	logic [15:0] ro_r, ro_nxt;       // reorder state
	logic [15:0] int_r, int_nxt;     // logging interval
	logic [QAW-1:0] qidx_r, qidx_nxt; // queue index
	// command answer
	logic [7:0]  stat_r, stat_nxt;   // status byte
	logic [7:0]  err_r, err_nxt;     // error byte
	logic [7:0]  cnt_r, cnt_nxt;     // sector count
	logic [7:0]  num_r, num_nxt;     // sector number
	logic        busy_r, busy_nxt;   // command in flight
	dfcc_state_t st_r, st_nxt;       // sequencer state
	logic [QAW-1:0] clr_r, clr_nxt;  // clear walk pointer
	logic        ld_r, ld_nxt;       // nv load pending after reset
	// outputs
	logic [31:0] prdata_nxt;         // read mux
	logic        pready_nxt, pslverr_nxt;
	logic        wcon_nxt, ro_on_nxt;
	logic [15:0] id85_nxt;
	// memory and nv wiring
	logic        q_we;               // queue write strobe
	logic [QAW-1:0] q_wa;            // queue write address
	logic [7:0]  q_wd;               // queue write byte
	logic [7:0]  q_rd;               // queue read byte
	logic        nv_we;              // persist strobe
	logic [15:0] nv_wc, nv_ro, nv_int; // persisted values
	logic        acc, wr, rd, go;    // bus access qualifiers
	// true cache state: forced policy overrides set-features
	function automatic logic cache_on(input logic [15:0] pol, input logic sf);
		case (pol)
			DFCC_WC_FORCEON: cache_on = 1'b1;
			DFCC_WC_FORCEOF: cache_on = 1'b0;
			default:         cache_on = sf;
		endcase
	endfunction : cache_on
	// is a feature code one we implement
	function automatic logic feat_known(input logic [15:0] fc);
		feat_known = (fc == DFCC_FC_WCACHE) || (fc == DFCC_FC_REORDER) ||
			(fc == DFCC_FC_LOGINT);
	endfunction : feat_known
	// one-cycle apb answer; access phase completes in its second cycle when CE_IN is high
	assign acc = PSEL_IN && PENABLE_IN && !PREADY_OUT;
	assign wr  = acc && PWRITE_IN;
	assign rd  = acc && !PWRITE_IN;
	assign go  = wr && (PADDR_IN == DFCC_OFS_CMD) && !busy_r; // launch
	dfcc_queue_mem #(.DEPTH(QSIZE), .AW(QAW)) u_mem (
		.clk_in   (CLK_SYS_IN),
		.ce_in    (CE_IN),
		.we_in    (q_we),
		.waddr_in (q_wa),
		.wdata_in (q_wd),
		.raddr_in (qra_r),
		.rdata_out(q_rd)
	);
	dfcc_nv_store u_nv (
		.clk_in  (CLK_SYS_IN),
		.ce_in   (CE_IN),
		.por_n_in(POR_N_IN),
		.we_in   (nv_we),
		.feat_in (fc_r),
		.val_in  (sv_r),
		.wc_out  (nv_wc),
		.ro_out  (nv_ro),
		.int_out (nv_int)
	);
	// software-written configuration registers
	always_comb begin
		fn_nxt     = fn_r;
		fc_nxt     = fc_r;
		sv_nxt     = sv_r;
		opt_nxt    = opt_r;
		sfc_nxt    = sfc_r;
		temp_nxt   = temp_r;
		period_nxt = period_r;
		limits_nxt = limits_r;
		qra_nxt    = qra_r;
		if (wr && !busy_r) begin
			case (PADDR_IN)
				DFCC_OFS_CMD:      fn_nxt     = PWDATA_IN[15:0];
				DFCC_OFS_FEAT:     fc_nxt     = PWDATA_IN[15:0];
				DFCC_OFS_STATE:    sv_nxt     = PWDATA_IN[15:0];
				DFCC_OFS_OPT:      opt_nxt    = PWDATA_IN[15:0];
				DFCC_OFS_TEMP:     temp_nxt   = PWDATA_IN[7:0];
				DFCC_OFS_PERIOD:   period_nxt = PWDATA_IN[15:0];
				DFCC_OFS_LIMITS:   limits_nxt = PWDATA_IN;
				DFCC_OFS_QRD:      qra_nxt    = PWDATA_IN[QAW-1:0];
				default: ; // read-only, unmapped or set-features cache (taken below)
			endcase
		end
		// set-features is separate host traffic, so it is taken even mid-command
		if (wr && PADDR_IN == DFCC_OFS_SETCACHE) sfc_nxt = PWDATA_IN[0];
	end
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			fn_r     <= DFCC_ZERO16;
			fc_r     <= DFCC_ZERO16;
			sv_r     <= DFCC_ZERO16;
			opt_r    <= DFCC_ZERO16;
			sfc_r    <= 1'b0;
			temp_r   <= 8'h00;
			period_r <= DFCC_ZERO16;
			limits_r <= 32'h00000000;
			qra_r    <= '0;
		end else if (CE_IN) begin
			fn_r     <= fn_nxt;
			fc_r     <= fc_nxt;
			sv_r     <= sv_nxt;
			opt_r    <= opt_nxt;
			sfc_r    <= sfc_nxt;
			temp_r   <= temp_nxt;
			period_r <= period_nxt;
			limits_r <= limits_nxt;
			qra_r    <= qra_nxt;
		end
	end
	// command sequencer: decode, execute, optional queue clear, finish
	always_comb begin
		st_nxt   = st_r;
		busy_nxt = busy_r;
		wc_nxt   = wc_r;
		ro_nxt   = ro_r;
		int_nxt  = int_r;
		qidx_nxt = qidx_r;
		clr_nxt  = clr_r;
		stat_nxt = stat_r;
		err_nxt  = err_r;
		cnt_nxt  = cnt_r;
		num_nxt  = num_r;
		ld_nxt   = 1'b0;
		q_we     = 1'b0;
		q_wa     = clr_r;
		q_wd     = DFCC_Q_EMPTY;
		nv_we    = 1'b0;
		// first cycle after hard reset adopts the last persisted settings
		if (ld_r) begin
			wc_nxt  = nv_wc;
			ro_nxt  = nv_ro;
			int_nxt = nv_int;
		end
		case (st_r)
			DFCC_IDLE: begin
				if (go) begin
					st_nxt   = DFCC_EXEC;
					busy_nxt = 1'b1;
				end
			end
			DFCC_EXEC: begin
				st_nxt   = DFCC_DONE;
				stat_nxt = DFCC_ST_OK;
				err_nxt  = DFCC_ER_NONE;
				cnt_nxt  = 8'h00;
				num_nxt  = 8'h00;
				case (fn_r)
					DFCC_FN_SET: begin
						case (fc_r)
							DFCC_FC_WCACHE: begin
								if (sv_r == DFCC_WC_FOLLOW || sv_r == DFCC_WC_FORCEON ||
									sv_r == DFCC_WC_FORCEOF) begin
									wc_nxt = sv_r;
									nv_we  = opt_r[DFCC_OPT_NV_BIT];
								end else begin
									stat_nxt = DFCC_ST_ERR; // undefined state
									err_nxt  = DFCC_ER_ABORT;
								end
							end
							DFCC_FC_REORDER: begin
								// disable request completes clean but is not applied
								if (sv_r == DFCC_RO_ENABLE) begin
									ro_nxt = sv_r;
									nv_we  = opt_r[DFCC_OPT_NV_BIT];
								end else if (sv_r != DFCC_RO_DISABLE) begin
									stat_nxt = DFCC_ST_ERR;
									err_nxt  = DFCC_ER_ABORT;
								end
							end
							DFCC_FC_LOGINT: begin
								if (sv_r == DFCC_INT_BAD) begin
									stat_nxt = DFCC_ST_ERR;
									err_nxt  = DFCC_ER_ABORT;
								end else begin
									int_nxt  = sv_r;
									nv_we    = opt_r[DFCC_OPT_NV_BIT];
									qidx_nxt = '0;
									clr_nxt  = '0;
									st_nxt   = DFCC_CLEAR;
								end
							end
							default: begin
								stat_nxt = DFCC_ST_ERR;
								err_nxt  = DFCC_ER_ABORT;
							end
						endcase
					end
					DFCC_FN_STATE: begin
						if (!feat_known(fc_r)) begin
							stat_nxt = DFCC_ST_ERR;
							err_nxt  = DFCC_ER_ABORT;
						end else begin
							{num_nxt, cnt_nxt} = (fc_r == DFCC_FC_WCACHE) ? wc_r :
								((fc_r == DFCC_FC_REORDER) ? ro_r : int_r);
						end
					end
					DFCC_FN_OPT: begin
						// option flags of a known feature: only persistence is offered
						if (!feat_known(fc_r)) begin
							stat_nxt = DFCC_ST_ERR;
							err_nxt  = DFCC_ER_ABORT;
						end else begin
							cnt_nxt = 8'h01;
						end
					end
					default: begin
						stat_nxt = DFCC_ST_ERR;
						err_nxt  = DFCC_ER_ABORT;
					end
				endcase
			end
			DFCC_CLEAR: begin
				// one byte per cycle; period and limits are never touched here
				q_we = 1'b1;
				q_wd = (clr_r == '0) ? temp_r : DFCC_Q_EMPTY;
				clr_nxt = QAW'(clr_r + 1'b1);
				if (clr_r == QAW'(QSIZE - 1)) st_nxt = DFCC_DONE;
			end
			DFCC_DONE: begin
				st_nxt   = DFCC_IDLE;
				busy_nxt = 1'b0;
			end
			default: begin
				st_nxt   = DFCC_IDLE;
				busy_nxt = 1'b0;
			end
		endcase
	end
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			st_r   <= DFCC_IDLE;
			busy_r <= 1'b0;
			wc_r   <= DFCC_WC_FOLLOW;
			ro_r   <= DFCC_RO_ENABLE;
			int_r  <= DFCC_INT_DEF;
			qidx_r <= '0;
			clr_r  <= '0;
			stat_r <= DFCC_ST_OK;
			err_r  <= DFCC_ER_NONE;
			cnt_r  <= 8'h00;
			num_r  <= 8'h00;
			ld_r   <= 1'b1;
		end else if (CE_IN) begin
			st_r   <= st_nxt;
			busy_r <= busy_nxt;
			wc_r   <= wc_nxt;
			ro_r   <= ro_nxt;
			int_r  <= int_nxt;
			qidx_r <= qidx_nxt;
			clr_r  <= clr_nxt;
			stat_r <= stat_nxt;
			err_r  <= err_nxt;
			cnt_r  <= cnt_nxt;
			num_r  <= num_nxt;
			ld_r   <= ld_nxt;
		end
	end
	// apb answer and status outputs, all registered
	always_comb begin
		pready_nxt  = acc;
		pslverr_nxt = 1'b0;
		prdata_nxt  = 32'h00000000;
		if (rd) begin
			case (PADDR_IN)
				DFCC_OFS_CMD:      prdata_nxt = {15'h0000, busy_r, fn_r};
				DFCC_OFS_FEAT:     prdata_nxt = {16'h0000, fc_r};
				DFCC_OFS_STATE:    prdata_nxt = {16'h0000, sv_r};
				DFCC_OFS_OPT:      prdata_nxt = {16'h0000, opt_r};
				DFCC_OFS_RESULT:   prdata_nxt = {stat_r, err_r, num_r, cnt_r};
				DFCC_OFS_SETCACHE: prdata_nxt = {31'h00000000, sfc_r};
				DFCC_OFS_INFO:     prdata_nxt = {ro_r[7:0], wc_r[7:0], int_r};
				DFCC_OFS_TEMP:     prdata_nxt = {24'h000000, temp_r};
				DFCC_OFS_QIDX:     prdata_nxt = 32'(qidx_r);
				DFCC_OFS_QRD:      prdata_nxt = {16'h0000, q_rd, 8'(qra_r)};
				DFCC_OFS_PERIOD:   prdata_nxt = {16'h0000, period_r};
				DFCC_OFS_LIMITS:   prdata_nxt = limits_r;
				default:           pslverr_nxt = 1'b1; // unmapped
			endcase
		end else if (wr) begin
			case (PADDR_IN)
				DFCC_OFS_CMD, DFCC_OFS_FEAT, DFCC_OFS_STATE, DFCC_OFS_OPT, DFCC_OFS_TEMP,
				DFCC_OFS_PERIOD, DFCC_OFS_LIMITS, DFCC_OFS_QRD: pslverr_nxt = busy_r; // busy
				DFCC_OFS_SETCACHE: pslverr_nxt = 1'b0; // never refused
				default: pslverr_nxt = 1'b1; // read-only or unmapped
			endcase
		end
		wcon_nxt  = cache_on(wc_r, sfc_r);
		ro_on_nxt = (ro_r == DFCC_RO_ENABLE);
		id85_nxt  = 16'h0000;
		id85_nxt[DFCC_ID85_BIT] = cache_on(wc_r, sfc_r);
	end
	always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			PRDATA_OUT    <= 32'h00000000;
			PREADY_OUT    <= 1'b0;
			PSLVERR_OUT   <= 1'b0;
			WCACHE_ON_OUT <= 1'b0;
			REORDER_OUT   <= 1'b1;
			ID_WORD85_OUT <= 16'h0000;
		end else if (CE_IN) begin
			PRDATA_OUT    <= prdata_nxt;
			PREADY_OUT    <= pready_nxt;
			PSLVERR_OUT   <= pslverr_nxt;
			WCACHE_ON_OUT <= wcon_nxt;
			REORDER_OUT   <= ro_on_nxt;
			ID_WORD85_OUT <= id85_nxt;
		end
	end
endmodule : dfcc_top

/* File: test/dfcc_chk_sva.sv */
`timescale 1ns/1ps
// pin-level checks of bus answers and cache state outputs
module dfcc_chk
	import dfcc_pkg::*;
#(
	parameter int QSIZE = DFCC_QSIZE // history queue entries
) (
	input wire logic        CLK_SYS_IN,    // clock
	input wire logic        RSTN_IN,       // hard reset
	input wire logic        POR_N_IN,      // power-on reset
	input wire logic        CE_IN,         // clock enable
	input wire logic        PSEL_IN,       // apb select
	input wire logic        PENABLE_IN,    // apb enable
	input wire logic        PWRITE_IN,     // apb direction
	input wire logic [7:0]  PADDR_IN,      // apb address
	input wire logic [31:0] PWDATA_IN,     // apb write data
	input wire logic [31:0] PRDATA_OUT,    // apb read data
	input wire logic        PREADY_OUT,    // apb ready
	input wire logic        PSLVERR_OUT,   // apb error
	input wire logic        WCACHE_ON_OUT, // true cache state
	input wire logic        REORDER_OUT,   // reordering on
	input wire logic [15:0] ID_WORD85_OUT  // identify word 85
);
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RSTN_IN);
	// an access phase gets its answer on the very next edge
	property p_ready_after_access;
		PSEL_IN && PENABLE_IN && CE_IN && !PREADY_OUT |=> PREADY_OUT;
	endproperty
	a_ready_after_access: assert property (p_ready_after_access)
		else $error("no ready one cycle after access phase");
	// ready only answers an access and lasts one cycle
	property p_ready_pulse;
		PREADY_OUT |-> $past(PSEL_IN) && $past(PENABLE_IN) ##1 !PREADY_OUT;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("ready without access or held too long");
	// error flag never stands apart from ready
	property p_err_with_ready;
		PSLVERR_OUT |-> PREADY_OUT;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready)
		else $error("error flag without ready");
	// addresses past the last register are refused
	property p_unmapped;
		PSEL_IN && PENABLE_IN && !PREADY_OUT && PADDR_IN > DFCC_OFS_LIMITS |=> PSLVERR_OUT;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped address not refused");
	// set-features cache requests always complete cleanly
	property p_setcache_ok;
		PSEL_IN && PENABLE_IN && PWRITE_IN && !PREADY_OUT
			&& PADDR_IN == DFCC_OFS_SETCACHE |=> !PSLVERR_OUT;
	endproperty
	a_setcache_ok: assert property (p_setcache_ok)
		else $error("set-features cache request refused");
	// identify word mirrors the true cache state in bit 5 only
	property p_id85;
		ID_WORD85_OUT == {10'h000, WCACHE_ON_OUT, 5'h00};
	endproperty
	a_id85: assert property (p_id85)
		else $error("identify word 85 disagrees with cache state");
	// outputs leave reset with reorder on and cache off
	property p_reset_defaults;
		$rose(RSTN_IN) |-> REORDER_OUT && !WCACHE_ON_OUT && ID_WORD85_OUT == 16'h0000;
	endproperty
	a_reset_defaults: assert property (p_reset_defaults)
		else $error("wrong output values at reset release");
	// disabling reorder is ignored, so it stays on
	property p_reorder_kept;
		REORDER_OUT;
	endproperty
	a_reorder_kept: assert property (p_reorder_kept)
		else $error("reordering switched off");
endmodule : dfcc_chk
bind dfcc_top dfcc_chk #(.QSIZE(QSIZE)) u_chk (
	.CLK_SYS_IN(CLK_SYS_IN), .RSTN_IN(RSTN_IN), .POR_N_IN(POR_N_IN), .CE_IN(CE_IN),
	.PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
	.PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
	.PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .WCACHE_ON_OUT(WCACHE_ON_OUT),
	.REORDER_OUT(REORDER_OUT), .ID_WORD85_OUT(ID_WORD85_OUT));

/* File: test/dfcc_host.sv */
`timescale 1ns/1ps
// host side: apb master that issues feature-control requests
module dfcc_host (
	input  wire logic        clk_in,      // clock
	output logic             psel_out,    // select
	output logic             penable_out, // enable
	output logic             pwrite_out,  // direction
	output logic      [7:0]  paddr_out,   // byte address
	output logic      [31:0] pwdata_out,  // write data
	input  wire logic [31:0] prdata_in,   // read data
	input  wire logic        pready_in,   // ready
	input  wire logic        pslverr_in   // error
);
	// bus idle from time zero
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 8'h00;
		pwdata_out = 32'h00000000;
	end
	// one transfer, held until ready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge clk_in);
		psel_out <= 1'b1;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		@(posedge clk_in);
		penable_out <= 1'b1;
		@(posedge clk_in);
		while (pready_in !== 1'b1) @(posedge clk_in);
		rd = prdata_in;
		er = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		// released lines must not keep looking valid
		paddr_out <= ~a;
		pwdata_out <= ~d;
	endtask : xfer
endmodule : dfcc_host

/* File: test/tb_top.sv */
`timescale 1ns/1ps
// self-checking bench for the feature-control block
module tb_top;
	import dfcc_pkg::*;
	localparam int QS = 8; // short queue keeps clears quick
	localparam logic [15:0] GOOD = {DFCC_ST_OK, DFCC_ER_NONE}; // clean end
	localparam logic [15:0] BAD = {DFCC_ST_ERR, DFCC_ER_ABORT}; // abort
	logic        clk, rstn, porn;       // clock and resets
	logic        psel, penable, pwrite; // apb controls
	logic [7:0]  paddr;                 // apb address
	logic [31:0] pwdata, prdata;        // apb data
	logic        pready, pslverr;       // apb answer
	logic        wc, reorder;           // live states
	logic [15:0] id85;                  // identify word
	logic [31:0] rdv, res;              // last read, last result
	logic        err;                   // last error flag
	int          n_errors = 0;          // mismatches
	int          checked = 0;           // comparisons
	int          cycles = 0;            // timeout count
	dfcc_host host (.clk_in(clk), .psel_out(psel), .penable_out(penable),
		.pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata),
		.prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr));
	dfcc_top #(.QSIZE(QS), .QAW(3)) dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .POR_N_IN(porn),
		.CE_IN(1'b1), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .WCACHE_ON_OUT(wc), .REORDER_OUT(reorder),
		.ID_WORD85_OUT(id85));
	task automatic conclude();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// reset; a power-on reset also clears the persistent copy
	task automatic do_reset(input logic por);
		@(posedge clk);
		rstn <= 1'b0;
		porn <= ~por;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		porn <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : do_reset
	// write must be accepted; then let outputs settle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rdv, err);
		chk({31'h00000000, err}, 32'h00000000);
		repeat (2) @(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		host.xfer(1'b0, a, 32'h00000000, rdv, err);
	endtask : rd
	// key sector fields, launch, poll busy under a bound
	task automatic cmd(input logic [15:0] fn, feat, st, opt);
		wr(DFCC_OFS_FEAT, {16'h0000, feat});
		wr(DFCC_OFS_STATE, {16'h0000, st});
		wr(DFCC_OFS_OPT, {16'h0000, opt});
		wr(DFCC_OFS_CMD, {16'h0000, fn});
		rdv = 32'h00010000;
		for (int i = 0; i < 40 && rdv[16] !== 1'b0; i++) rd(DFCC_OFS_CMD);
		chk({15'h0000, rdv[16], 16'h0000}, 32'h00000000);
		rd(DFCC_OFS_RESULT);
		res = rdv;
	endtask : cmd
	task automatic chk_st(input logic [15:0] exp);
		chk({16'h0000, res[31:16]}, {16'h0000, exp});
	endtask : chk_st
	task automatic cache(input logic on);
		chk({15'h0000, wc, id85}, {15'h0000, on, 10'h000, on, 5'h00});
	endtask : cache
	task automatic t_defaults();
		rd(DFCC_OFS_INFO);
		chk(rdv, 32'h01010001);
		cache(1'b0);
	endtask : t_defaults
	// follow, force both ways, ignored requests while forced
	task automatic t_cache();
		wr(DFCC_OFS_SETCACHE, 32'h00000001);
		cache(1'b1);
		cmd(DFCC_FN_SET, DFCC_FC_WCACHE, DFCC_WC_FORCEOF, 16'h0000);
		chk_st(GOOD);
		cache(1'b0);
		wr(DFCC_OFS_SETCACHE, 32'h00000001);
		cache(1'b0);
		cmd(DFCC_FN_SET, DFCC_FC_WCACHE, DFCC_WC_FORCEON, 16'h0000);
		cache(1'b1);
		wr(DFCC_OFS_SETCACHE, 32'h00000000);
		cache(1'b1);
		cmd(DFCC_FN_SET, DFCC_FC_WCACHE, DFCC_WC_FOLLOW, 16'h0000);
		cache(1'b0);
		wr(DFCC_OFS_SETCACHE, 32'h00000001);
		cache(1'b1);
		cmd(DFCC_FN_STATE, DFCC_FC_WCACHE, 16'h0000, 16'h0000);
		chk(res, {GOOD, DFCC_WC_FOLLOW});
	endtask : t_cache
	task automatic t_reorder();
		cmd(DFCC_FN_SET, DFCC_FC_REORDER, DFCC_RO_DISABLE, 16'h0000);
		chk_st(GOOD);
		cmd(DFCC_FN_STATE, DFCC_FC_REORDER, 16'h0000, 16'h0000);
		chk(res, {GOOD, DFCC_RO_ENABLE});
		cmd(DFCC_FN_SET, DFCC_FC_REORDER, DFCC_RO_ENABLE, 16'h0000);
		chk({31'h00000000, reorder}, 32'h00000001);
	endtask : t_reorder
	// interval change clears the queue, keeps period and limits
	task automatic t_interval();
		wr(DFCC_OFS_PERIOD, 32'h00000005);
		wr(DFCC_OFS_LIMITS, 32'h4B5005F6);
		wr(DFCC_OFS_TEMP, 32'h0000002A);
		cmd(DFCC_FN_SET, DFCC_FC_LOGINT, 16'h1234, 16'h0000);
		chk_st(GOOD);
		rd(DFCC_OFS_QIDX);
		chk(rdv, 32'h00000000);
		for (int i = 0; i < QS; i++) begin
			wr(DFCC_OFS_QRD, 32'(i));
			rd(DFCC_OFS_QRD);
			chk(rdv, {16'h0000, (i == 0) ? 8'h2A : DFCC_Q_EMPTY, 8'(i)});
		end
		rd(DFCC_OFS_PERIOD);
		chk(rdv, 32'h00000005);
		rd(DFCC_OFS_LIMITS);
		chk(rdv, 32'h4B5005F6);
		cmd(DFCC_FN_STATE, DFCC_FC_LOGINT, 16'h0000, 16'h0000);
		chk(res, {GOOD, 16'h1234});
		cmd(DFCC_FN_OPT, DFCC_FC_LOGINT, 16'h0000, 16'h0000);
		chk(res, {GOOD, 16'h0001});
	endtask : t_interval
	// refused requests abort and change nothing
	task automatic t_bad();
		logic [15:0] tab [4][3] = '{'{DFCC_FN_SET, DFCC_FC_WCACHE, 16'h0004},
			'{DFCC_FN_SET, 16'h0004, 16'h0001}, '{DFCC_FN_STATE, 16'hD000, 16'h0001},
			'{16'h0004, DFCC_FC_WCACHE, 16'h0001}};
		cmd(DFCC_FN_SET, DFCC_FC_LOGINT, DFCC_INT_BAD, 16'h0000);
		chk_st(BAD);
		for (int i = 0; i < 4; i++) begin
			cmd(tab[i][0], tab[i][1], tab[i][2], 16'h0000);
			chk_st(BAD);
		end
		rd(DFCC_OFS_INFO);
		chk(rdv, 32'h01011234);
		host.xfer(1'b0, 8'h30, 32'h00000000, rdv, err);
		chk({31'h00000000, err}, 32'h00000001);
	endtask : t_bad
	// persistent setting survives hard reset, volatile one does not
	task automatic t_persist();
		cmd(DFCC_FN_SET, DFCC_FC_WCACHE, DFCC_WC_FORCEON, 16'h0001);
		chk_st(GOOD);
		cmd(DFCC_FN_SET, DFCC_FC_LOGINT, 16'h0007, 16'h0000);
		do_reset(1'b0);
		rd(DFCC_OFS_INFO);
		chk(rdv, 32'h01020001);
		cache(1'b1);
		do_reset(1'b1);
		rd(DFCC_OFS_INFO);
		chk(rdv, 32'h01010001);
	endtask : t_persist
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// main sequence
	initial begin
		rstn = 1'b0;
		porn = 1'b0;
		do_reset(1'b1);
		t_defaults();
		t_cache();
		t_reorder();
		t_interval();
		t_bad();
		t_persist();
		conclude();
	end
	// hang guard, far above the expected run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_errors++;
			conclude();
		end
	end
endmodule : tb_top
